// File: sep_map.vh
`ifndef SEP_MAP_VH
`define SEP_MAP_VH
// Internal register addresses
`define SEP_REG_CONTROL     8'ha1
`define SEP_REG_WORD_ADDR   8'ha2
`define SEP_REG_WRITE_VAL   8'ha3
`define SEP_REG_READ_VAL    8'ha4
// Control register fields
`define SEP_CTL_HV_BIT      0
`define SEP_CTL_ERASE_BIT   1
`define SEP_CTL_WRITE_BIT   2
`define SEP_CTL_READ_BIT    3
// Store geometry
`define SEP_WORDS           32
`define SEP_INDEX_W         5
`define SEP_WORD_W          16
// Reset and erased values
`define SEP_RESET_WORD      16'h0000
`define SEP_ERASED_WORD     16'h0000
// Timing
`define SEP_CLK_HZ          10000000
`define SEP_PROG_TIME_MS    12
`define SEP_PROG_CYCLES     ((`SEP_PROG_TIME_MS * `SEP_CLK_HZ) / 1000)
`endif

// File: sep_port.v
`timescale 1ns/1ps
`default_nettype none
`include "sep_map.vh"

module sep_port #(
    parameter [6:0]  TARGET_ADDR = 7'h3c,              // Arbitrary value
    parameter        TIMER_W     = 24,
    parameter [23:0] PROG_CYCLES = `SEP_PROG_CYCLES
) (
    input  wire        i_clk,
    input  wire        i_reset_n,
    input  wire        i_speed_input_pin,
    input  wire        i_tach_output_pin,
    input  wire        i_tach_level,
    output wire        o_tach_output_pin,
    output wire        o_tach_output_pin_oe,
    output reg         o_serial_mode,
    output reg         o_prog_busy,
    output reg         o_prog_high_voltage
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RX   = 3'd1;
    localparam [2:0] ST_ACK  = 3'd2;
    localparam [2:0] ST_TX   = 3'd3;
    localparam [2:0] ST_RACK = 3'd4;

    localparam [1:0] PH_ADDR = 2'd0;
    localparam [1:0] PH_REG  = 2'd1;
    localparam [1:0] PH_DATA = 2'd2;

    reg  [2:0]  scl_sync;
    reg  [2:0]  sda_sync;
    reg  [2:0]  state;
    reg  [1:0]  phase;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shift;
    reg         rw;
    reg         byte_sel;
    reg  [7:0]  reg_ptr;
    reg  [7:0]  hi_byte;
    reg         sda_low;
    reg         master_nack;
    reg  [15:0] ctl;
    reg  [15:0] word_addr;
    reg  [15:0] new_word;
    reg  [15:0] read_word;
    reg  [15:0] store [0:`SEP_WORDS-1];
    reg  [TIMER_W-1:0] timer;
    reg         op_erase;
    reg  [`SEP_INDEX_W-1:0] op_index;
    reg  [15:0] op_word;
    reg         wr_pulse;
    reg  [15:0] wr_data;
    reg  [15:0] tx_word;

    wire scl      = scl_sync[1];
    wire sda      = sda_sync[1];
    wire scl_rise = scl_sync[1] & ~scl_sync[2];
    wire scl_fall = ~scl_sync[1] & scl_sync[2];
    wire start_c  = scl & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    wire stop_c   = scl & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

    // Register read mux; unmapped addresses read as zero
    function [15:0] reg_read;
        input [7:0] a;
        begin
            case (a)
                `SEP_REG_CONTROL:   reg_read = ctl;
                `SEP_REG_WORD_ADDR: reg_read = word_addr;
                `SEP_REG_WRITE_VAL: reg_read = new_word;
                `SEP_REG_READ_VAL:  reg_read = read_word;
                default:            reg_read = 16'h0000;
            endcase
        end
    endfunction

    // Word the read pointer selects, loaded when a read frame starts
    wire [15:0] ptr_value = reg_read(reg_ptr);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling: two flops before any logic, third stage only for edges
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_sync <= 3'b111;
            sda_sync <= 3'b111;
        end else begin
            scl_sync <= {scl_sync[1:0], i_speed_input_pin};
            sda_sync <= {sda_sync[1:0], i_tach_output_pin};
        end
    end

    // Open-drain data: serial side only pulls low; tach passes through before serial mode
    assign o_tach_output_pin    = 1'b0;
    assign o_tach_output_pin_oe = o_serial_mode ? sda_low : ~i_tach_level;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial target state machine; outputs change on falling clock edges
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state         <= ST_IDLE;
            phase         <= PH_ADDR;
            bit_cnt       <= 4'h0;
            shift         <= 8'h00;
            rw            <= 1'b0;
            byte_sel      <= 1'b0;
            reg_ptr       <= 8'h00;
            hi_byte       <= 8'h00;
            sda_low       <= 1'b0;
            master_nack   <= 1'b0;
            o_serial_mode <= 1'b0;
            wr_pulse      <= 1'b0;
            wr_data       <= 16'h0000;
            tx_word       <= 16'h0000;
        end else begin
            wr_pulse <= 1'b0;
            if (start_c) begin
                // Repeated start also lands here; no wake-up needed
                state    <= ST_RX;
                phase    <= PH_ADDR;
                bit_cnt  <= 4'h0;
                byte_sel <= 1'b0;
                sda_low  <= 1'b0;
            end else if (stop_c) begin
                state   <= ST_IDLE;
                sda_low <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            case (phase)
                                PH_ADDR: begin
                                    if (shift[7:1] == TARGET_ADDR) begin
                                        rw            <= shift[0];
                                        sda_low       <= 1'b1;
                                        state         <= ST_ACK;
                                        o_serial_mode <= 1'b1;
                                    end else begin
                                        state <= ST_IDLE;
                                    end
                                end
                                PH_REG: begin
                                    reg_ptr <= shift;
                                    sda_low <= 1'b1;
                                    state   <= ST_ACK;
                                end
                                default: begin
                                    // High byte first, commit on low byte
                                    if (!byte_sel) begin
                                        hi_byte <= shift;
                                    end else begin
                                        wr_data  <= {hi_byte, shift};
                                        wr_pulse <= 1'b1;
                                    end
                                    byte_sel <= ~byte_sel;
                                    sda_low  <= 1'b1;
                                    state    <= ST_ACK;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                // Read answers the pointer set by the prior write frame
                                tx_word <= ptr_value;
                                sda_low <= ~ptr_value[15];
                                bit_cnt <= 4'h1;
                                state   <= ST_TX;
                            end else begin
                                sda_low <= 1'b0;
                                state   <= ST_RX;
                                if (phase != PH_DATA) begin
                                    phase <= phase + 2'd1;
                                end
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_low <= 1'b0;
                                state   <= ST_RACK;
                            end else begin
                                sda_low <= byte_sel ? ~tx_word[4'd7 - bit_cnt[2:0]]
                                                    : ~tx_word[4'd15 - bit_cnt];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            master_nack <= sda;
                        end else if (scl_fall) begin
                            // Only two bytes are served per read frame
                            if (!master_nack && !byte_sel) begin
                                byte_sel <= 1'b1;
                                sda_low  <= ~tx_word[7];
                                bit_cnt  <= 4'h1;
                                state    <= ST_TX;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and programming sequencer
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl                 <= `SEP_RESET_WORD;
            word_addr           <= `SEP_RESET_WORD;
            new_word            <= `SEP_RESET_WORD;
            read_word           <= `SEP_RESET_WORD;
            timer               <= {TIMER_W{1'b0}};
            o_prog_busy         <= 1'b0;
            o_prog_high_voltage <= 1'b0;
            op_erase            <= 1'b0;
            op_index            <= {`SEP_INDEX_W{1'b0}};
            op_word             <= `SEP_RESET_WORD;
        end else begin
            // Data-out tracks the addressed word every cycle
            read_word <= store[word_addr[`SEP_INDEX_W-1:0]];
            if (wr_pulse) begin
                case (reg_ptr)
                    `SEP_REG_CONTROL:   ctl       <= wr_data;
                    `SEP_REG_WORD_ADDR: word_addr <= wr_data;
                    `SEP_REG_WRITE_VAL: new_word  <= wr_data;
                    default:            ctl       <= ctl;
                endcase
            end
            if (o_prog_busy) begin
                // Count the programming interval; ignore new requests meanwhile
                if (timer == PROG_CYCLES[TIMER_W-1:0] - 1'b1) begin
                    o_prog_busy         <= 1'b0;
                    o_prog_high_voltage <= 1'b0;
                    timer               <= {TIMER_W{1'b0}};
                end else begin
                    timer <= timer + 1'b1;
                end
            end else if (wr_pulse && reg_ptr == `SEP_REG_CONTROL
                         && wr_data[`SEP_CTL_HV_BIT]
                         && (wr_data[`SEP_CTL_ERASE_BIT] || wr_data[`SEP_CTL_WRITE_BIT])) begin
                o_prog_busy         <= 1'b1;
                o_prog_high_voltage <= 1'b1;
                op_erase            <= wr_data[`SEP_CTL_ERASE_BIT];
                op_index            <= word_addr[`SEP_INDEX_W-1:0];
                op_word             <= new_word;
                timer               <= {TIMER_W{1'b0}};
            end
        end
    end

    // Store words are nonvolatile content, so they take no reset
    always @(posedge i_clk) begin
        if (o_prog_busy && timer == PROG_CYCLES[TIMER_W-1:0] - 1'b1) begin
            store[op_index] <= op_erase ? `SEP_ERASED_WORD : op_word;
        end
    end

endmodule
`default_nettype wire

// File: sep_port_end.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: sep_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sep_port_checker #(
    parameter [23:0] PROG_CYCLES = 24'h01_d4c0
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_speed_input_pin,
    input wire logic i_tach_output_pin,
    input wire logic i_tach_level,
    input wire logic o_tach_output_pin,
    input wire logic o_tach_output_pin_oe,
    input wire logic o_serial_mode,
    input wire logic o_prog_busy,
    input wire logic o_prog_high_voltage
);
    logic [23:0] run;
    // Busy cycles so far; a counter, since a long repeat would choke the tools
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run <= 24'h00_0000;
        end else begin
            run <= o_prog_busy ? run + 24'h00_0001 : 24'h00_0000;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // Start of a programming interval, then its first cycles
    sequence s_prog_start;
        !o_prog_busy ##1 o_prog_busy;
    endsequence
    sequence s_prog_held;
        (o_prog_busy && o_prog_high_voltage)[*8];
    endsequence
    property p_hv_busy;
        o_prog_high_voltage == o_prog_busy;
    endproperty
    property p_prog_held;
        s_prog_start |-> s_prog_held;
    endproperty
    property p_busy_max;
        o_prog_busy |-> run < PROG_CYCLES;
    endproperty
    property p_busy_end;
        $fell(o_prog_busy) |-> run == PROG_CYCLES;
    endproperty
    property p_serial_sticky;
        o_serial_mode |=> o_serial_mode;
    endproperty
    property p_prog_needs_serial;
        $rose(o_prog_busy) |-> o_serial_mode;
    endproperty
    property p_tach_pass;
        !o_serial_mode |-> o_tach_output_pin_oe == !i_tach_level;
    endproperty
    property p_open_drain;
        o_tach_output_pin == 1'b0;
    endproperty
    // Data may only move while the serial clock is low
    property p_sda_scl_low;
        o_serial_mode && $past(o_serial_mode) && $changed(o_tach_output_pin_oe)
            |-> !i_speed_input_pin;
    endproperty
    a_hv_busy: assert property (p_hv_busy) else $error("voltage not tied to busy");
    a_prog_held: assert property (p_prog_held) else $error("busy dropped early");
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    a_busy_end: assert property (p_busy_end) else $error("busy wrong length");
    a_serial_sticky: assert property (p_serial_sticky) else $error("serial lost");
    a_prog_needs_serial: assert property (p_prog_needs_serial) else $error("busy w/o bus");
    a_tach_pass: assert property (p_tach_pass) else $error("tach not passed");
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved, clk high");
endmodule
bind sep_port sep_port_checker #(.PROG_CYCLES(PROG_CYCLES)) u_sep_port_checker (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_speed_input_pin(i_speed_input_pin),
    .i_tach_output_pin(i_tach_output_pin), .i_tach_level(i_tach_level),
    .o_tach_output_pin(o_tach_output_pin), .o_tach_output_pin_oe(o_tach_output_pin_oe),
    .o_serial_mode(o_serial_mode), .o_prog_busy(o_prog_busy),
    .o_prog_high_voltage(o_prog_high_voltage)
);
`default_nettype wire

// File: sep_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda_pull
);
    // Bus idles released; clock stands high outside frames
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Start: data falls while clock high
    task automatic start();
        o_scl = 1'b1;
        hold(2);
        o_sda_pull = 1'b1;
        hold(2);
        o_scl = 1'b0;
        hold(2);
    endtask
    task automatic stop();
        o_sda_pull = 1'b1;
        hold(2);
        o_scl = 1'b1;
        hold(2);
        o_sda_pull = 1'b0;
        hold(4);
    endtask
    // Eight bits MSB first plus ninth; long low phase gives the target time
    task automatic xfer(input [8:0] d, output [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            o_sda_pull = !d[i];
            hold(3);
            o_scl = 1'b1;
            hold(2);
            r[i] = i_sda;
            hold(1);
            o_scl = 1'b0;
            hold(2);
        end
    endtask
    task automatic reg_write(input [6:0] dev, input [7:0] a, input [15:0] v,
                             output [3:0] ack);
        logic [8:0] r0, r1, r2, r3;
        start();
        xfer({dev, 2'b01}, r0);
        xfer({a, 1'b1}, r1);
        xfer({v[15:8], 1'b1}, r2);
        xfer({v[7:0], 1'b1}, r3);
        stop();
        ack = ~{r0[0], r1[0], r2[0], r3[0]};
    endtask
    task automatic reg_read(input [6:0] dev, input [7:0] a, output [15:0] v,
                            output [3:0] ack);
        logic [8:0] r0, r1, r2, r3, r4;
        start();
        xfer({dev, 2'b01}, r0);
        xfer({a, 1'b1}, r1);
        stop();
        start();
        xfer({dev, 2'b11}, r2);
        xfer(9'h1_fe, r3);
        xfer(9'h1_ff, r4);
        stop();
        v = {r3[8:1], r4[8:1]};
        // Last slot is the host's own NACK, so it counts as answered
        ack = ~{r0[0], r1[0], r2[0], 1'b0};
    endtask
endmodule
`default_nettype wire

// File: tb_sep_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "sep_map.vh"
module tb_sep_port;
    localparam [6:0]  TGT  = 7'h3c; // Arbitrary target address
    localparam [23:0] PROG = 24'h00_01f4;
    logic        i_clk        = 1'b0;
    logic        i_reset_n    = 1'b0;
    logic        i_tach_level = 1'b1;
    wire         scl, pull, sda, oe, serial, busy, hv;
    int          miscompares  = 0;
    int          compares     = 0;
    logic [23:0] run          = 24'h00_0000;
    logic [23:0] last_run     = 24'h00_0000;
    logic [15:0] rd;
    logic [3:0]  ack;
    logic [15:0] idx [2]      = '{16'h0005, 16'h001f};
    logic [15:0] val [2]      = '{16'h0105, 16'hbeef};
    // Open-drain wire with pull-up: released reads high
    assign sda = !(pull || oe);
    always #50 i_clk = ~i_clk;
    sep_port #(.TARGET_ADDR(TGT), .PROG_CYCLES(PROG)) u_sep_port (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_speed_input_pin(scl),
        .i_tach_output_pin(sda), .i_tach_level(i_tach_level), .o_tach_output_pin(),
        .o_tach_output_pin_oe(oe), .o_serial_mode(serial), .o_prog_busy(busy),
        .o_prog_high_voltage(hv)
    );
    sep_host_model u_sep_host_model (
        .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull)
    );
    // Length of each busy run, kept once it ends
    always @(posedge i_clk) begin
        run <= (busy === 1'b1) ? run + 24'h00_0001 : 24'h00_0000;
        if (busy !== 1'b1 && run != 24'h00_0000) last_run <= run;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input [7:0] a, input [15:0] v);
        u_sep_host_model.reg_write(TGT, a, v, ack);
        check("write ack", 16'h000f, {12'h000, ack});
    endtask
    task automatic rd_chk(input [7:0] a, input [15:0] exp);
        u_sep_host_model.reg_read(TGT, a, rd, ack);
        check("read ack", 16'h000f, {12'h000, ack});
        check("read data", exp, rd);
    endtask
    // Bounded wait; hv must follow busy, run must equal the interval
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        // The run length is latched one edge after busy falls
        @(negedge i_clk);
        check("busy run", PROG[15:0], last_run[15:0]);
        check("hv off", 16'h0000, {15'h0000, hv});
    endtask
    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #4_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (19) @(negedge i_clk);
        i_tach_level = 1'b0;
        @(negedge i_clk);
        check("tach oe", 16'h0001, {15'h0000, oe});
        i_tach_level = 1'b1;
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clk);
        u_sep_host_model.reg_write(TGT ^ 7'h01, 8'ha3, 16'h0001, ack);
        check("foreign ack", 16'h0000, {12'h000, ack});
        check("serial idle", 16'h0000, {15'h0000, serial});
        wr(`SEP_REG_WRITE_VAL, 16'h1234);
        check("serial on", 16'h0001, {15'h0000, serial});
        rd_chk(`SEP_REG_WRITE_VAL, 16'h1234);
        rd_chk(8'h10, 16'h0000);
        wr(`SEP_REG_CONTROL, 16'h0004);
        wr(`SEP_REG_CONTROL, 16'h0009);
        check("no start", 16'h0000, {15'h0000, busy});
        for (int k = 0; k < 2; k++) begin
            wr(`SEP_REG_WORD_ADDR, idx[k]);
            wr(`SEP_REG_WRITE_VAL, 16'h0000);
            wr(`SEP_REG_CONTROL, 16'h0003);
            check("erase busy", 16'h0001, {15'h0000, busy});
            check("hv on", 16'h0001, {15'h0000, hv});
            if (k == 0) wr(`SEP_REG_CONTROL, 16'h0005);
            wait_idle();
            rd_chk(`SEP_REG_READ_VAL, 16'h0000);
            wr(`SEP_REG_WRITE_VAL, val[k]);
            wr(`SEP_REG_CONTROL, 16'h0005);
            check("write busy", 16'h0001, {15'h0000, busy});
            wait_idle();
            rd_chk(`SEP_REG_READ_VAL, val[k]);
        end
        wr(`SEP_REG_WORD_ADDR, idx[0]);
        rd_chk(`SEP_REG_READ_VAL, val[0]);
        wrap_up();
    end
endmodule
`default_nettype wire
